// file: hdl/adc_port_pkg.sv
package adc_port_pkg;

	// Serial word geometry
	localparam int CMD_W   = 8;
	localparam int DATA_W  = 24;
	localparam int REG16_W = 16;
	localparam int BYTE_W  = 8;
	localparam int CNT_W   = 5;
	localparam int ONES_W  = 6;
	localparam int ADDR_W  = 3;

	// Command word fields
	localparam int RD_BIT  = 6;
	localparam int ADDR_HI = 5;
	localparam int ADDR_LO = 3;

	// Register addresses carried in the command word
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_MODE   = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_DATA   = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_ID     = 3'h4;

	// Clock counts per access
	localparam logic [CNT_W-1:0] CMD_LAST = 5'h07;
	localparam logic [CNT_W-1:0] LEN_8    = 5'h08;
	localparam logic [CNT_W-1:0] LEN_16   = 5'h10;
	localparam logic [CNT_W-1:0] LEN_24   = 5'h18;
	localparam logic [ONES_W-1:0] ONES_LAST = 6'h1F;

	// Default register contents
	localparam logic [REG16_W-1:0] MODE_DEF   = 16'h000A;
	localparam logic [REG16_W-1:0] CONFIG_DEF = 16'h0710;

	// Mode register fields
	localparam int MODE_OP_HI  = 15;
	localparam int MODE_OP_LO  = 13;
	localparam int MODE_PSW    = 12;
	localparam int MODE_CLK_HI = 7;
	localparam int MODE_CLK_LO = 6;
	localparam int MODE_RATE_HI = 3;
	localparam int MODE_RATE_LO = 0;

	// Configuration register fields
	localparam int CFG_UNIPOLAR = 12;
	localparam int CFG_GAIN_HI  = 10;
	localparam int CFG_GAIN_LO  = 8;
	localparam int CFG_REF_HI   = 7;
	localparam int CFG_REF_LO   = 6;
	localparam int CFG_CHAN_HI  = 3;
	localparam int CFG_CHAN_LO  = 0;

	localparam logic [DATA_W-1:0] MIDSCALE = 24'h800000;

	// Ready held high this long before the output register is rewritten
	localparam int CLK_PERIOD_NS = 10;
	localparam int UPDATE_NS     = 100;
	localparam int UPD_W         = 4;
	localparam int UPDATE_CYC_INT = (UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [UPD_W-1:0] UPDATE_CYC = UPD_W'(UPDATE_CYC_INT);
	localparam logic [UPD_W-1:0] UPD_ONE    = 4'h1;

	typedef enum logic [1:0] {ST_CMD, ST_WRITE, ST_READ} port_state_t;

endpackage

// file: hdl/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             en_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_i) begin
		if (en_i) begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule

// file: hdl/sigma_delta_adc_serial_port.sv
`timescale 1ns/1ps
// What this block does
// - Sixteen-bit register writes take exactly 16 clocks, one data bit each.
// - Each register has a fixed clock count that ends its transfer.
// - Every finished transfer returns to waiting for a command write.
// - The first command bit is a gate that must be zero.
// - A one at the gate position keeps the port waiting on that bit.
// - After a zero gate, seven more bits complete the eight-bit command.
// - Writes arrive on data-in, reads leave on data-out, timed by serial clock.
// - Data-out low while idle signals a new conversion word.
// - Reading the conversion word returns the ready indication high.
// - Ready goes high before the output register is updated.
// - Active-low chip select enables the serial port.
// - Chip select may be tied low for three-wire use.
// - Clocks while deselected are ignored.
// - Thirty-two consecutive ones reset the port and all registers.
// - Mode register holds rate, clock source, power switch and operating mode.
// - Configuration register holds channel, reference and gain.
// - Bipolar results use offset binary, midscale meaning zero.
// - The conversion word is 24 bits, read with 24 clocks.
// - With select high the port ignores clock and data.
module sigma_delta_adc_serial_port #(
	parameter logic [7:0] ID_VALUE = 8'h5A // Arbitrary identification value
) (
	input  wire logic                             ref_clk_i,
	input  wire logic                             srst_i,
	input  wire logic                             ce_i,
	input  wire logic                             sclk_i,
	input  wire logic                             cs_n_i,
	input  wire logic                             din_i,
	input  wire logic [adc_port_pkg::DATA_W-1:0]  conv_data_i,
	input  wire logic                             conv_valid_i,
	output logic                                  dout_o,
	output logic                                  dout_oe_n_o,
	output logic                                  data_ready_n_o,
	output logic [2:0]                            op_mode_o,
	output logic                                  power_switch_o,
	output logic [1:0]                            clk_sel_o,
	output logic [3:0]                            rate_o,
	output logic [3:0]                            channel_o,
	output logic [1:0]                            ref_sel_o,
	output logic [2:0]                            gain_o,
	output logic                                  bipolar_o
);
	import adc_port_pkg::*;

	// ---------------- Serial clock domain ----------------
	logic                 lrst;
	logic                 rdy_n_l;
	logic                 active;
	logic [ONES_W-1:0]    ones;
	logic                 ones_hit;
	port_state_t          state;
	logic [CNT_W-1:0]     cnt;
	logic [CNT_W-1:0]     len;
	logic                 last;
	logic [CMD_W-2:0]     cmd_sr;
	logic [CMD_W-1:0]     cmd;
	logic [ADDR_W-1:0]    addr;
	logic [DATA_W-1:0]    rx_sr;
	logic [DATA_W-1:0]    tx_sr;
	logic [DATA_W-1:0]    next_tx;
	logic [REG16_W-1:0]   next_word;
	logic [REG16_W-1:0]   mode_reg;
	logic [REG16_W-1:0]   config_reg;
	logic                 cmd_done;
	logic                 wr_done;
	logic                 data_read_done;
	logic                 read_lock;
	logic                 wr_tgl;
	logic                 rd_tgl;
	logic                 rst_tgl;
	logic                 dout;

	// ---------------- Reference clock domain ----------------
	logic [3:0]           ref_sync;
	logic                 s_cs_n;
	logic                 s_wr;
	logic                 s_rd;
	logic                 s_rst;
	logic                 wr_seen;
	logic                 rd_seen;
	logic                 rst_seen;
	logic                 wr_ev;
	logic                 rd_ev;
	logic                 rst_ev;
	logic [REG16_W-1:0]   mode_q;
	logic [REG16_W-1:0]   config_q;
	logic [DATA_W-1:0]    conv_hold;
	logic [DATA_W-1:0]    data_reg;
	logic [UPD_W-1:0]     upd_cnt;
	logic                 rdy_n;
	logic                 oe_n;

	bit_sync #(.WIDTH(2)) u_link_sync (
		.clk_i (sclk_i),
		.en_i  (1'b1),
		.d_i   ({srst_i, rdy_n}),
		.q_o   ({lrst, rdy_n_l})
	);

	assign active    = !cs_n_i;
	assign ones_hit  = active && din_i && (ones == ONES_LAST);
	assign cmd       = {cmd_sr, din_i};
	assign last      = (cnt == len - 5'h01);
	assign next_word = {rx_sr[REG16_W-2:0], din_i};
	assign cmd_done  = active && !ones_hit && (state == ST_CMD) && (cnt == CMD_LAST);
	assign wr_done   = active && !ones_hit && (state == ST_WRITE) && last;
	assign data_read_done = active && !ones_hit && (state == ST_READ) && last
		&& (addr == ADDR_DATA);

	function automatic logic [CNT_W-1:0] len_of(input logic [ADDR_W-1:0] a);
		if (a == ADDR_MODE || a == ADDR_CONFIG)
			return LEN_16;
		else if (a == ADDR_DATA)
			return LEN_24;
		else
			return LEN_8;
	endfunction

	// Ones detector runs beside the command machine
	always_ff @(posedge sclk_i) begin
		if (lrst || ones_hit)
			ones <= '0;
		else if (active)
			ones <= din_i ? ones + 6'h01 : '0;
	end

	always_ff @(posedge sclk_i) begin
		if (lrst || ones_hit) begin
			state <= ST_CMD;
			cnt   <= '0;
		end else if (active) begin
			unique case (state)
				ST_CMD: begin
					if (cnt == '0 && din_i) begin
						cnt <= '0;
					end else if (cnt == CMD_LAST) begin
						state <= cmd[RD_BIT] ? ST_READ : ST_WRITE;
						cnt   <= '0;
					end else begin
						cnt <= cnt + 5'h01;
					end
				end
				ST_WRITE, ST_READ: begin
					if (last) begin
						state <= ST_CMD;
						cnt   <= '0;
					end else begin
						cnt <= cnt + 5'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sclk_i) begin
		if (lrst || ones_hit) begin
			cmd_sr <= '0;
			addr   <= '0;
			len    <= LEN_8;
		end else if (active && state == ST_CMD && !(cnt == '0 && din_i)) begin
			cmd_sr <= cmd[CMD_W-2:0];
			if (cnt == CMD_LAST) begin
				addr <= cmd[ADDR_HI:ADDR_LO];
				len  <= len_of(cmd[ADDR_HI:ADDR_LO]);
			end
		end
	end

	always_ff @(posedge sclk_i) begin
		if (active && state == ST_WRITE)
			rx_sr <= {rx_sr[DATA_W-2:0], din_i};
	end

	always_ff @(posedge sclk_i) begin
		if (lrst || ones_hit) begin
			mode_reg   <= MODE_DEF;
			config_reg <= CONFIG_DEF;
		end else if (wr_done && addr == ADDR_MODE) begin
			mode_reg <= next_word;
		end else if (wr_done && addr == ADDR_CONFIG) begin
			config_reg <= next_word;
		end
	end

	// Read word is left aligned so the MSB always leaves first
	always_comb begin
		next_tx = '0;
		unique case (cmd[ADDR_HI:ADDR_LO])
			ADDR_STATUS: next_tx[DATA_W-1 -: BYTE_W] = {rdy_n_l | read_lock, 3'h0,
				config_reg[CFG_CHAN_HI:CFG_CHAN_LO]};
			ADDR_MODE:   next_tx[DATA_W-1 -: REG16_W] = mode_reg;
			ADDR_CONFIG: next_tx[DATA_W-1 -: REG16_W] = config_reg;
			ADDR_DATA:   next_tx = data_reg;
			ADDR_ID:     next_tx[DATA_W-1 -: BYTE_W] = ID_VALUE;
			default:     next_tx = '0;
		endcase
	end

	always_ff @(posedge sclk_i) begin
		if (cmd_done && cmd[RD_BIT])
			tx_sr <= next_tx;
		else if (active && state == ST_READ)
			tx_sr <= {tx_sr[DATA_W-2:0], 1'b0};
	end

	// Hides the stale ready level until the cleared one crosses back
	always_ff @(posedge sclk_i) begin
		if (lrst || ones_hit)
			read_lock <= 1'b0;
		else if (data_read_done)
			read_lock <= 1'b1;
		else if (rdy_n_l)
			read_lock <= 1'b0;
	end

	always_ff @(posedge sclk_i) begin
		if (lrst) begin
			wr_tgl  <= 1'b0;
			rd_tgl  <= 1'b0;
			rst_tgl <= 1'b0;
		end else begin
			if (wr_done || ones_hit)
				wr_tgl <= !wr_tgl;
			if (data_read_done)
				rd_tgl <= !rd_tgl;
			if (ones_hit)
				rst_tgl <= !rst_tgl;
		end
	end

	// Output changes after the falling edge; idle shows the ready level
	always_ff @(negedge sclk_i) begin
		if (lrst)
			dout <= 1'b1;
		else if (state == ST_READ)
			dout <= tx_sr[DATA_W-1];
		else
			dout <= rdy_n_l | read_lock;
	end

	assign dout_o = dout;

	// ---------------- Reference clock side ----------------
	bit_sync #(.WIDTH(4)) u_ref_sync (
		.clk_i (ref_clk_i),
		.en_i  (ce_i),
		.d_i   ({cs_n_i, wr_tgl, rd_tgl, rst_tgl}),
		.q_o   (ref_sync)
	);

	assign {s_cs_n, s_wr, s_rd, s_rst} = ref_sync;
	assign wr_ev  = s_wr ^ wr_seen;
	assign rd_ev  = s_rd ^ rd_seen;
	assign rst_ev = s_rst ^ rst_seen;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			wr_seen  <= 1'b0;
			rd_seen  <= 1'b0;
			rst_seen <= 1'b0;
		end else if (ce_i) begin
			wr_seen  <= s_wr;
			rd_seen  <= s_rd;
			rst_seen <= s_rst;
		end
	end

	// Pin released while deselected; the held data-out level (the ready level while idle) shows once select falls
	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			oe_n <= 1'b1;
		else if (ce_i)
			oe_n <= s_cs_n;
	end

	assign dout_oe_n_o = oe_n;

	// Register copies are stable here: the link side waits a whole write before changing them
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			mode_q   <= MODE_DEF;
			config_q <= CONFIG_DEF;
		end else if (ce_i && wr_ev) begin
			mode_q   <= mode_reg;
			config_q <= config_reg;
		end
	end

	assign op_mode_o      = mode_q[MODE_OP_HI:MODE_OP_LO];
	assign power_switch_o = mode_q[MODE_PSW];
	assign clk_sel_o      = mode_q[MODE_CLK_HI:MODE_CLK_LO];
	assign rate_o         = mode_q[MODE_RATE_HI:MODE_RATE_LO];
	assign channel_o      = config_q[CFG_CHAN_HI:CFG_CHAN_LO];
	assign ref_sel_o      = config_q[CFG_REF_HI:CFG_REF_LO];
	assign gain_o         = config_q[CFG_GAIN_HI:CFG_GAIN_LO];
	assign bipolar_o      = !config_q[CFG_UNIPOLAR];

	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			conv_hold <= '0;
		else if (ce_i && conv_valid_i)
			conv_hold <= conv_data_i;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i || (ce_i && rst_ev))
			upd_cnt <= '0;
		else if (ce_i && conv_valid_i)
			upd_cnt <= UPDATE_CYC;
		else if (ce_i && upd_cnt != '0)
			upd_cnt <= upd_cnt - UPD_ONE;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i || (ce_i && rst_ev))
			data_reg <= '0;
		else if (ce_i && upd_cnt == UPD_ONE)
			data_reg <= config_q[CFG_UNIPOLAR] ? conv_hold : conv_hold ^ MIDSCALE;
	end

	// A fresh result outranks a read that finishes in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || (ce_i && rst_ev))
			rdy_n <= 1'b1;
		else if (ce_i) begin
			if (conv_valid_i)
				rdy_n <= 1'b1;
			else if (upd_cnt == UPD_ONE)
				rdy_n <= 1'b0;
			else if (rd_ev)
				rdy_n <= 1'b1;
		end
	end

	assign data_ready_n_o = rdy_n;

	// ---------------- Checks ----------------
	gate_wait_a: assert property (@(posedge sclk_i) disable iff (lrst)
		(state == ST_CMD && cnt == '0 && active && din_i && !ones_hit)
		|=> (state == ST_CMD && cnt == '0))
		else $error("gate one did not hold the command wait");

	cmd_bits_a: assert property (@(posedge sclk_i) disable iff (lrst)
		(state == ST_CMD && cnt == '0 && active && !din_i) ##1 (active && !ones_hit)[*7]
		|=> (state != ST_CMD))
		else $error("command not taken after seven bits");

	word_len_a: assert property (@(posedge sclk_i) disable iff (lrst)
		(state == ST_WRITE && (addr == ADDR_MODE || addr == ADDR_CONFIG)) |-> len == LEN_16)
		else $error("sixteen bit write has wrong length");

	read_len_a: assert property (@(posedge sclk_i) disable iff (lrst)
		(state == ST_READ && addr == ADDR_DATA) |-> len == LEN_24)
		else $error("data read has wrong length");

	end_return_a: assert property (@(posedge sclk_i) disable iff (lrst)
		(state != ST_CMD && active && last && !ones_hit) |=> (state == ST_CMD && cnt == '0))
		else $error("transfer end did not return to command wait");

	ones_reset_a: assert property (@(posedge sclk_i) disable iff (lrst)
		ones_hit |=> (state == ST_CMD && cnt == '0 && mode_reg == MODE_DEF
		&& config_reg == CONFIG_DEF))
		else $error("ones reset did not restore defaults");

	idle_hold_a: assert property (@(posedge sclk_i) disable iff (lrst)
		cs_n_i |=> ($stable(state) && $stable(cnt) && $stable(mode_reg)))
		else $error("port moved while deselected");

	mode_write_a: assert property (@(posedge sclk_i) disable iff (lrst)
		(wr_done && addr == ADDR_MODE) |=> mode_reg == $past(next_word))
		else $error("mode write not stored");

	read_flag_a: assert property (@(posedge sclk_i) disable iff (lrst)
		data_read_done |=> (rd_tgl != $past(rd_tgl) && read_lock))
		else $error("data read completion not signalled");

	rdy_update_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		(upd_cnt != '0) |-> rdy_n)
		else $error("ready low during output update");

	data_stable_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!rdy_n |=> (rdy_n || $stable(data_reg)))
		else $error("output register changed while ready low");

	rdy_low_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		(ce_i && upd_cnt == UPD_ONE && !conv_valid_i && !rst_ev) |=> !rdy_n)
		else $error("ready not asserted after update");

	coding_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		(ce_i && upd_cnt == UPD_ONE && !rst_ev && !config_q[CFG_UNIPOLAR])
		|=> data_reg == ($past(conv_hold) ^ MIDSCALE))
		else $error("bipolar result not offset binary");

	data_read_c: cover property (@(posedge sclk_i) disable iff (lrst) data_read_done);
	mode_write_c: cover property (@(posedge sclk_i) disable iff (lrst)
		wr_done && addr == ADDR_MODE);
	ones_reset_c: cover property (@(posedge sclk_i) disable iff (lrst) ones_hit);
	rdy_low_c: cover property (@(posedge ref_clk_i) disable iff (srst_i) $fell(rdy_n));

endmodule

// file: sim/adc_host_model.sv
`timescale 1ns/1ps
module adc_host_model (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o,
	input  wire logic dout_i
);
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		din_o  = 1'b1;
	end

	// One bit: clock falls and data changes, data-out is taken at the rising edge
	task automatic xbit(input logic b, output logic s);
		sclk_o = 1'b0;
		din_o  = b;
		#6;
		s      = dout_i;
		sclk_o = 1'b1;
		#6;
	endtask

	// Deselected clocks with zeros that would start a command if they were taken
	task automatic idle_clocks(input int n);
		logic s;
		repeat (n) xbit(1'b0, s);
		din_o = 1'b1;
	endtask

	// Leading ones, command, data bits and trailing ones inside one select frame
	task automatic frame(input int gap, input logic [7:0] cmd, input int n,
			input logic [23:0] wd, input int tail, output logic [23:0] rd,
			output logic rdy);
		logic s;
		cs_n_o = 1'b0;
		#40;
		rd  = '0;
		rdy = 1'b1;
		for (int i = 0; i < gap; i++) begin
			xbit(1'b1, s);
			rdy = s;
		end
		for (int i = 7; i >= 0; i--) xbit(cmd[i], s);
		for (int i = n - 1; i >= 0; i--) begin
			xbit(wd[i], s);
			rd = {rd[22:0], s};
		end
		repeat (tail) xbit(1'b1, s);
		din_o = 1'b1;
		#6;
		cs_n_o = 1'b1;
		#30;
	endtask
endmodule

// file: sim/sigma_delta_adc_serial_port_test.sv
`timescale 1ns/1ps
module sigma_delta_adc_serial_port_test;
	import adc_port_pkg::*;

	logic        ref_clk_i = 1'b0;
	logic        srst_i;
	logic        ce_i;
	logic [23:0] conv_data_i;
	logic        conv_valid_i;
	logic        sclk;
	logic        cs_n;
	logic        din;
	logic        dout_o;
	logic        dout_oe_n_o;
	logic        data_ready_n_o;
	logic [2:0]  op_mode_o;
	logic        power_switch_o;
	logic [1:0]  clk_sel_o;
	logic [3:0]  rate_o;
	logic [3:0]  channel_o;
	logic [1:0]  ref_sel_o;
	logic [2:0]  gain_o;
	logic        bipolar_o;
	logic [19:0] obs;
	int          err_count;
	int          n_tests;
	logic [31:0] rng = 32'h0C90;
	logic [15:0] mode;
	logic [15:0] cfg;
	logic [23:0] rd;
	logic [23:0] cw;
	logic        sr;
	logic        rdy_n;

	always #5 ref_clk_i = ~ref_clk_i;

	assign obs = {op_mode_o, power_switch_o, clk_sel_o, rate_o, channel_o, ref_sel_o, gain_o,
		bipolar_o};

	sigma_delta_adc_serial_port DUT (
		.ref_clk_i      (ref_clk_i),
		.srst_i         (srst_i),
		.ce_i           (ce_i),
		.sclk_i         (sclk),
		.cs_n_i         (cs_n),
		.din_i          (din),
		.conv_data_i    (conv_data_i),
		.conv_valid_i   (conv_valid_i),
		.dout_o         (dout_o),
		.dout_oe_n_o    (dout_oe_n_o),
		.data_ready_n_o (data_ready_n_o),
		.op_mode_o      (op_mode_o),
		.power_switch_o (power_switch_o),
		.clk_sel_o      (clk_sel_o),
		.rate_o         (rate_o),
		.channel_o      (channel_o),
		.ref_sel_o      (ref_sel_o),
		.gain_o         (gain_o),
		.bipolar_o      (bipolar_o)
	);

	adc_host_model host (
		.sclk_o (sclk),
		.cs_n_o (cs_n),
		.din_o  (din),
		.dout_i (dout_oe_n_o ? 1'b1 : dout_o)
	);

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	function automatic logic [19:0] fexp(input logic [15:0] m, input logic [15:0] c);
		return {m[15:13], m[12], m[7:6], m[3:0], c[3:0], c[7:6], c[10:8], ~c[12]};
	endfunction

	function automatic logic [23:0] exp_data(input logic [23:0] d, input logic [15:0] c);
		return c[CFG_UNIPOLAR] ? d : d ^ MIDSCALE;
	endfunction

	task automatic chk_word(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic xfer(input int gap, input logic [7:0] cmd, input int n,
			input logic [23:0] wd, input int tail);
		// Ready on data-out is current only after two link clocks
		fork
			host.frame(gap, cmd, n, wd, tail, rd, sr);
			begin
				#40;
				chk_bit("pin driven", 1'b0, dout_oe_n_o);
			end
		join
		if (gap > 0) chk_bit("ready on data-out", rdy_n, sr);
		chk_bit("pin released", 1'b1, dout_oe_n_o);
	endtask

	// Conversion offer; ready must go high first and low once the word is loaded
	task automatic convert(input logic [23:0] d);
		@(negedge ref_clk_i);
		conv_data_i  = d;
		conv_valid_i = 1'b1;
		@(negedge ref_clk_i);
		conv_valid_i = 1'b0;
		@(negedge ref_clk_i);
		chk_bit("ready high before update", 1'b1, data_ready_n_o);
		repeat (UPDATE_CYC_INT - 2) @(negedge ref_clk_i);
		chk_bit("ready held during update", 1'b1, data_ready_n_o);
		@(negedge ref_clk_i);
		chk_bit("ready after update", 1'b0, data_ready_n_o);
		rdy_n = 1'b0;
	endtask

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#200000;
		err_count++;
		final_report();
	end

	initial begin
		srst_i       = 1'b1;
		ce_i         = 1'b1;
		conv_data_i  = '0;
		conv_valid_i = 1'b0;
		err_count    = 0;
		n_tests      = 0;
		rdy_n        = 1'b1;
		mode         = MODE_DEF;
		cfg          = CONFIG_DEF;
		// Link reset needs sclk edges while reset is high
		host.idle_clocks(6);
		@(negedge ref_clk_i);
		srst_i = 1'b0;
		xfer(40, 8'hFF, 0, '0, 0);
		repeat (10) @(negedge ref_clk_i);
		chk_word("defaults", {4'h0, fexp(mode, cfg)}, {4'h0, obs});
		chk_bit("ready after reset", 1'b1, data_ready_n_o);
		$display("Test reset done");
		for (int it = 0; it < 6; it++) begin
			host.idle_clocks(3 + int'(xs() % 5));
			mode = 16'(xs());
			xfer(1 + int'(xs() % 3), 8'h08, 16, {8'h00, mode}, 0);
			cfg               = 16'(xs());
			cfg[CFG_UNIPOLAR] = it[0];
			xfer(1, 8'h10, 16, {8'h00, cfg}, 0);
			xfer(1, 8'h48, 16, '0, 0);
			chk_word("mode read", {8'h00, mode}, rd);
			xfer(1, 8'h50, 16, '0, 0);
			chk_word("config read", {8'h00, cfg}, rd);
			repeat (6) @(negedge ref_clk_i);
			chk_word("fields", {4'h0, fexp(mode, cfg)}, {4'h0, obs});
			cw = 24'(xs());
			convert(24'(xs()));
			convert(cw);
			// An offer while the enable is low must be lost
			@(negedge ref_clk_i);
			ce_i         = 1'b0;
			conv_data_i  = ~cw;
			conv_valid_i = 1'b1;
			repeat (3) @(negedge ref_clk_i);
			conv_valid_i = 1'b0;
			ce_i         = 1'b1;
			chk_bit("ready frozen by enable", 1'b0, data_ready_n_o);
			xfer(3, 8'h40, 8, '0, 0);
			chk_word("status read", {16'h0, 4'h0, cfg[3:0]}, rd);
			xfer(1, 8'h58, 24, '0, 0);
			chk_word("data read", exp_data(cw, cfg), rd);
			repeat (6) @(negedge ref_clk_i);
			chk_bit("ready after read", 1'b1, data_ready_n_o);
			rdy_n = 1'b1;
			$display("Test pass %0d done", it);
		end
		xfer(1, 8'h68, 8, '0, 0);
		chk_word("unmapped read", '0, rd);
		// Ones run through a config write into the command phase
		xfer(0, 8'h10, 16, 24'h00FFFF, 24);
		mode = MODE_DEF;
		cfg  = CONFIG_DEF;
		repeat (10) @(negedge ref_clk_i);
		chk_word("defaults after ones", {4'h0, fexp(mode, cfg)}, {4'h0, obs});
		xfer(1, 8'h50, 16, '0, 0);
		chk_word("config after ones", {8'h00, CONFIG_DEF}, rd);
		$display("Test ones reset done");
		final_report();
	end
endmodule
